// file: verilog/gpx_port.sv
// Eight-pin GPIO port: masked data, pad setup, pin mux and interrupts
//
// Contract
// - Eight-bit pin mask; bit n selects pin n; only selected pins act.
// - Pin read returns level of selected pins, zero for others.
// - Raw and masked interrupt status readable, one bit per pin.
// - Enabling interrupts unmasks selected pins; others keep their mask.
// - Disabling masks selected pins; raw status still shows them.
// - Clear removes pending flags of selected pins only.
// - Per-pin drive strength: 2, 4, 8 mA or 8 mA slew limited.
// - Per-pin pad type: push-pull, open-drain, each with pulls, or analog.
// - Input pins store pad settings; only pulls affect the input.
// - Pad configuration reads back exactly as written.
// - At most one peripheral function per pin, chosen by code.
// - Analog enable only reaches pins that carry a converter input; on other pins analog mode just turns the driver off.
// - Data address carries the pin mask; masked pins change together.
// - Pin mode: software input, software output or hardware control.
// - Interrupt trigger: falling, rising, both edges, low or high level.
//
// The strobed register port and the address map were decided locally.
`default_nettype none
`include "gpx_consts.svh"
module gpx_port (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// Register port
	input  wire logic [11:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rdata,
	// Pads
	input  wire logic [7:0]  pad_in,
	output logic      [7:0]  pad_out,
	output logic      [7:0]  pad_oe,
	output logic      [15:0] pad_drive,
	output logic      [7:0]  pad_slew_limit,
	output logic      [7:0]  pad_pullup,
	output logic      [7:0]  pad_pulldown,
	output logic      [7:0]  pad_analog_en,
	// Peripheral functions
	input  wire logic [15:0] func_out,
	input  wire logic [15:0] func_oe,
	output logic      [15:0] func_in,
	// Interrupt
	output logic             irq
);
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	function automatic logic is_od(input logic [2:0] t);
		return t == gpx_pkg::pad_open_drain || t == gpx_pkg::pad_open_drain_pullup
			|| t == gpx_pkg::pad_open_drain_pulldown;
	endfunction

	logic [7:0]      pin_meta;
	logic [7:0]      pin_lvl;
	logic [7:0]      data_q;
	logic [7:0][1:0] drive_q;
	logic [7:0][2:0] pad_q;
	logic [7:0][1:0] dir_q;
	logic [7:0][2:0] itype_q;
	logic [7:0][3:0] alt_q;
	logic [2:0]      pin_index;
	logic [7:0]      next_pad_out;
	logic [7:0]      next_pad_oe;
	logic [7:0]      od_mask;
	logic [31:0]     next_rdata;

	gpx_irq_if irq_bus ();

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire       in_data   = addr[11:10] == 2'h0;
	wire [7:0] pin_select_mask = addr[9:2];
	wire [7:0] analog_pins = `GPX_ANALOG_PINS;
	wire       wr_data   = wr_en & in_data;
	wire       wr_dir    = wr_en & hit(addr, `GPX_OFF_DIR);
	wire       wr_itype  = wr_en & hit(addr, `GPX_OFF_ITYPE);
	wire       wr_pad    = wr_en & hit(addr, `GPX_OFF_PAD);
	wire       wr_pinidx = wr_en & hit(addr, `GPX_OFF_PINIDX);
	wire       wr_alt    = wr_en & hit(addr, `GPX_OFF_ALT);
	wire [1:0] mode_w    = wdata[`GPX_F_MODE_HI:`GPX_F_MODE_LO];
	wire [2:0] type_w    = wdata[`GPX_F_TYPE_HI:`GPX_F_TYPE_LO];
	wire [3:0] alt_code_w = wdata[`GPX_F_ALT_HI:`GPX_F_ALT_LO];
	// Undefined codes are dropped so readback only ever shows legal settings
	wire       dir_ok    = mode_w <= `GPX_DIR_LAST;
	wire       pad_ok    = type_w <= `GPX_PAD_LAST;
	wire       itype_ok  = type_w <= `GPX_ITYPE_LAST;

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_meta <= 8'h00;
			pin_lvl  <= 8'h00;
		end else begin
			pin_meta <= pad_in;
			pin_lvl  <= pin_meta;
		end
	end

	// ****************************************************************
	// Configuration storage
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			data_q    <= 8'h00;
			pin_index <= 3'h0;
			for (int i = 0; i < 8; i++) begin
				drive_q[i] <= `GPX_RST_DRIVE;
				pad_q[i]   <= `GPX_RST_PAD;
				dir_q[i]   <= `GPX_RST_DIR;
				itype_q[i] <= `GPX_RST_ITYPE;
				alt_q[i]   <= `GPX_RST_ALT;
			end
		end else begin
			if (wr_data)
				data_q <= (data_q & ~pin_select_mask) | (wdata[7:0] & pin_select_mask);
			if (wr_pinidx)
				pin_index <= wdata[2:0];
			for (int i = 0; i < 8; i++) begin
				if (wr_dir && dir_ok && wdata[i])
					dir_q[i] <= mode_w;
				if (wr_itype && itype_ok && wdata[i])
					itype_q[i] <= type_w;
				if (wr_pad && pad_ok && wdata[i]) begin
					drive_q[i] <= mode_w;
					pad_q[i]   <= type_w;
				end
				if (wr_alt && wdata[2:0] == 3'(i))
					alt_q[i] <= alt_code_w;
			end
		end
	end

	// ****************************************************************
	// Pad control and pin mux
	// ****************************************************************
	// pad_out and pad_oe are registered so they never see decode glitches; the drive, slew, pull and analog outputs are not
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			logic hw;
			logic val;
			logic en;
			hw  = dir_q[i] == gpx_pkg::dir_hw_controlled;
			// Only the one function named by the code reaches the pin
			val = hw ? func_out[alt_q[i]] : data_q[i];
			en  = hw ? (alt_q[i] != 4'h0) & func_oe[alt_q[i]]
				: dir_q[i] == gpx_pkg::dir_sw_output;
			od_mask[i] = is_od(pad_q[i]);
			if (pad_q[i] == gpx_pkg::pad_analog) begin
				next_pad_out[i] = 1'b0;
				next_pad_oe[i]  = 1'b0;
			end else if (od_mask[i]) begin
				next_pad_out[i] = 1'b0;
				next_pad_oe[i]  = en & ~val;
			end else begin
				next_pad_out[i] = val;
				next_pad_oe[i]  = en;
			end
			pad_drive[2*i +: 2] = drive_q[i];
			pad_slew_limit[i]   = drive_q[i] == gpx_pkg::drive_high_slew_limited;
			// Pulls act whatever the direction
			pad_pullup[i]   = pad_q[i] == gpx_pkg::pad_push_pull_pullup
				|| pad_q[i] == gpx_pkg::pad_open_drain_pullup;
			pad_pulldown[i] = pad_q[i] == gpx_pkg::pad_push_pull_pulldown
				|| pad_q[i] == gpx_pkg::pad_open_drain_pulldown;
			// Pins without a converter input cannot become one
			pad_analog_en[i] = (pad_q[i] == gpx_pkg::pad_analog)
				& analog_pins[i];
		end
	end

	// Several pins on one function OR together; software avoids that
	always_comb begin
		func_in = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (dir_q[i] == gpx_pkg::dir_hw_controlled && alt_q[i] != 4'h0)
				func_in[alt_q[i]] = func_in[alt_q[i]] | pin_lvl[i];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pad_out <= 8'h00;
			pad_oe  <= 8'h00;
		end else begin
			pad_out <= next_pad_out;
			pad_oe  <= next_pad_oe;
		end
	end

	// ****************************************************************
	// Interrupt detector
	// ****************************************************************
	assign irq_bus.level  = pin_lvl;
	assign irq_bus.itype  = itype_q;
	assign irq_bus.en_set = (wr_en & hit(addr, `GPX_OFF_INT_EN)) ? wdata[7:0] : 8'h00;
	assign irq_bus.en_clr = (wr_en & hit(addr, `GPX_OFF_INT_DIS)) ? wdata[7:0] : 8'h00;
	assign irq_bus.clr    = (wr_en & hit(addr, `GPX_OFF_INT_RAW)) ? wdata[7:0] : 8'h00;
	assign irq            = irq_bus.irq;

	gpx_irq_det u_det (
		.core_clk (core_clk),
		.rstn     (rstn),
		.bus      (irq_bus.det)
	);

	// ****************************************************************
	// Read path
	// ****************************************************************
	wire [31:0] cfg_word = {12'h000, alt_q[pin_index], 1'b0, itype_q[pin_index],
		2'h0, dir_q[pin_index], 1'b0, pad_q[pin_index], 2'h0, drive_q[pin_index]};

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (in_data)
			next_rdata = {24'h00_0000, pin_lvl & pin_select_mask};
		else if (hit(addr, `GPX_OFF_PINIDX))
			next_rdata = {29'h000_0000, pin_index};
		else if (hit(addr, `GPX_OFF_PINCFG))
			next_rdata = cfg_word;
		else if (hit(addr, `GPX_OFF_INT_EN) || hit(addr, `GPX_OFF_INT_DIS))
			next_rdata = {24'h00_0000, irq_bus.en};
		else if (hit(addr, `GPX_OFF_INT_RAW))
			next_rdata = {24'h00_0000, irq_bus.raw};
		else if (hit(addr, `GPX_OFF_INT_MSK))
			next_rdata = {24'h00_0000, irq_bus.masked};
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rdata <= 32'h0000_0000;
		else if (rd_en)
			rdata <= next_rdata;
		else
			rdata <= 32'h0000_0000;
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_masked_read;
		@(posedge core_clk) disable iff (!rstn)
		(rd_en && in_data) |=> rdata == {24'h00_0000, $past(pin_lvl & pin_select_mask)};
	endproperty
	a_masked_read: assert property (p_masked_read) else $error("pin read not masked");

	property p_masked_write;
		@(posedge core_clk) disable iff (!rstn)
		wr_data |=> ((data_q & $past(pin_select_mask)) == $past(wdata[7:0] & pin_select_mask))
			&& ((data_q & ~$past(pin_select_mask)) == $past(data_q & ~pin_select_mask));
	endproperty
	a_masked_write: assert property (p_masked_write) else $error("data write mask wrong");

	property p_pad_back;
		@(posedge core_clk) disable iff (!rstn)
		(wr_pad && pad_ok && wdata[0]) |=> (pad_q[0] == $past(type_w))
			&& (drive_q[0] == $past(mode_w));
	endproperty
	a_pad_back: assert property (p_pad_back) else $error("pad setting not stored");

	property p_od_no_high;
		@(posedge core_clk) disable iff (!rstn)
		(pad_oe & pad_out & $past(od_mask)) == 8'h00;
	endproperty
	a_od_no_high: assert property (p_od_no_high) else $error("open-drain pin drove high");

	property p_analog_only;
		@(posedge core_clk) disable iff (!rstn)
		((pad_analog_en & ~`GPX_ANALOG_PINS) == 8'h00);
	endproperty
	a_analog_only: assert property (p_analog_only) else $error("analog on non-analog pin");

	property p_hw_mux;
		@(posedge core_clk) disable iff (!rstn)
		(dir_q[0] == gpx_pkg::dir_hw_controlled && alt_q[0] != 4'h0
			&& pad_q[0] == gpx_pkg::pad_push_pull && func_oe[alt_q[0]])
			|=> pad_oe[0] && pad_out[0] == $past(func_out[alt_q[0]]);
	endproperty
	a_hw_mux: assert property (p_hw_mux) else $error("pin not driven by its function");

	property p_pad_refused;
		@(posedge core_clk) disable iff (!rstn)
		(wr_pad && !pad_ok) |=> (pad_q == $past(pad_q)) && (drive_q == $past(drive_q));
	endproperty
	a_pad_refused: assert property (p_pad_refused) else $error("illegal pad type stored");

	property p_pad_unsel;
		@(posedge core_clk) disable iff (!rstn)
		(wr_pad && !wdata[1]) |=> (pad_q[1] == $past(pad_q[1]))
			&& (drive_q[1] == $past(drive_q[1]));
	endproperty
	a_pad_unsel: assert property (p_pad_unsel) else $error("unselected pin pad changed");

	property p_analog_quiet;
		@(posedge core_clk) disable iff (!rstn)
		(pad_q[0] == gpx_pkg::pad_analog) |=> !pad_oe[0];
	endproperty
	a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin driven");
endmodule // gpx_port
`default_nettype wire

// file: verilog/gpx_consts.svh
// Offsets, field positions, reset values and limits of the GPIO port
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses, 12-bit space)
// ****************************************************************
`define GPX_OFF_DIR      12'h400
`define GPX_OFF_ITYPE    12'h404
`define GPX_OFF_PAD      12'h408
`define GPX_OFF_PINIDX   12'h40C
`define GPX_OFF_PINCFG   12'h410
`define GPX_OFF_ALT      12'h414
`define GPX_OFF_INT_EN   12'h418
`define GPX_OFF_INT_DIS  12'h41C
`define GPX_OFF_INT_RAW  12'h420
`define GPX_OFF_INT_MSK  12'h424

// ****************************************************************
// Write field positions
// ****************************************************************
`define GPX_F_MODE_HI    9
`define GPX_F_MODE_LO    8
`define GPX_F_TYPE_HI    14
`define GPX_F_TYPE_LO    12
`define GPX_F_ALT_HI     19
`define GPX_F_ALT_LO     16

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define GPX_RST_DRIVE    2'h0
`define GPX_RST_PAD      3'h0
`define GPX_RST_DIR      2'h0
`define GPX_RST_ITYPE    3'h0
`define GPX_RST_ALT      4'h0
`define GPX_PAD_LAST     3'h6
`define GPX_ITYPE_LAST   3'h4
`define GPX_DIR_LAST     2'h2
`define GPX_ANALOG_PINS  8'h0F

`endif

// file: verilog/gpx_pkg.sv
// Types shared by the GPIO port modules
`default_nettype none
package gpx_pkg;
	typedef enum logic [1:0] {
		drive_low               = 2'h0,
		drive_mid               = 2'h1,
		drive_high              = 2'h2,
		drive_high_slew_limited = 2'h3
	} gpx_drive_e;
	typedef enum logic [2:0] {
		pad_push_pull           = 3'h0,
		pad_push_pull_pullup    = 3'h1,
		pad_push_pull_pulldown  = 3'h2,
		pad_open_drain          = 3'h3,
		pad_open_drain_pullup   = 3'h4,
		pad_open_drain_pulldown = 3'h5,
		pad_analog              = 3'h6
	} gpx_pad_e;
	typedef enum logic [1:0] {
		dir_sw_input      = 2'h0,
		dir_sw_output     = 2'h1,
		dir_hw_controlled = 2'h2
	} gpx_dir_e;
	typedef enum logic [2:0] {
		trig_falling = 3'h0,
		trig_rising  = 3'h1,
		trig_both    = 3'h2,
		trig_low     = 3'h3,
		trig_high    = 3'h4
	} gpx_itype_e;
endpackage
`default_nettype wire

// file: verilog/gpx_irq_if.sv
// Link between the port core and its interrupt detector
`default_nettype none
interface gpx_irq_if;
	logic [7:0]  level;
	logic [23:0] itype;
	logic [7:0]  en_set;
	logic [7:0]  en_clr;
	logic [7:0]  clr;
	logic [7:0]  raw;
	logic [7:0]  en;
	logic [7:0]  masked;
	logic        irq;
	modport ctl (output level, itype, en_set, en_clr, clr, input raw, en, masked, irq);
	modport det (input level, itype, en_set, en_clr, clr, output raw, en, masked, irq);
endinterface
`default_nettype wire

// file: verilog/gpx_irq_det.sv
// Per-pin interrupt detection, sticky raw status and mask
`default_nettype none
`include "gpx_consts.svh"
module gpx_irq_det (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	// Link to the port core
	gpx_irq_if.det    bus
);
	logic [7:0] prev;
	logic       primed;
	logic [7:0] ev;
	logic [7:0] raw_q;
	logic [7:0] en_q;

	// ****************************************************************
	// Trigger decode
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			case (gpx_pkg::gpx_itype_e'(bus.itype[3*i +: 3]))
				gpx_pkg::trig_falling: ev[i] = primed & prev[i] & ~bus.level[i];
				gpx_pkg::trig_rising:  ev[i] = primed & ~prev[i] & bus.level[i];
				gpx_pkg::trig_both:    ev[i] = primed & (prev[i] ^ bus.level[i]);
				gpx_pkg::trig_low:     ev[i] = ~bus.level[i];
				gpx_pkg::trig_high:    ev[i] = bus.level[i];
				default:               ev[i] = 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// Status and mask
	// ****************************************************************
	// No edges in the first cycle out of reset: prev holds no real history yet
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prev   <= 8'h00;
			primed <= 1'b0;
			raw_q  <= 8'h00;
			en_q   <= 8'h00;
		end else begin
			prev   <= bus.level;
			primed <= 1'b1;
			raw_q  <= (raw_q & ~bus.clr) | ev;
			en_q   <= (en_q | bus.en_set) & ~bus.en_clr;
		end
	end

	assign bus.raw    = raw_q;
	assign bus.en     = en_q;
	assign bus.masked = raw_q & en_q;
	assign bus.irq    = |bus.masked;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_irq_or;
		@(posedge core_clk) disable iff (!rstn)
		bus.irq == |(raw_q & en_q);
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("irq not OR of unmasked raw");

	property p_clear;
		@(posedge core_clk) disable iff (!rstn)
		(bus.clr != 8'h00) |=> ((raw_q & $past(bus.clr) & ~$past(ev)) == 8'h00);
	endproperty
	a_clear: assert property (p_clear) else $error("cleared pin still pending");

	property p_unmask;
		@(posedge core_clk) disable iff (!rstn)
		(bus.en_set != 8'h00) |=> ((en_q & $past(bus.en_set & ~bus.en_clr))
			== $past(bus.en_set & ~bus.en_clr));
	endproperty
	a_unmask: assert property (p_unmask) else $error("enable did not unmask");

	property p_mask;
		@(posedge core_clk) disable iff (!rstn)
		(bus.en_clr != 8'h00) |=> ((en_q & $past(bus.en_clr)) == 8'h00);
	endproperty
	a_mask: assert property (p_mask) else $error("disable did not mask");

	property p_raw_set;
		@(posedge core_clk) disable iff (!rstn)
		(ev != 8'h00) |=> ((raw_q & $past(ev)) == $past(ev));
	endproperty
	a_raw_set: assert property (p_raw_set) else $error("event lost from raw status");
endmodule // gpx_irq_det
`default_nettype wire

// file: sim/gpx_pin_model.sv
// Board-side model of the eight pins: external drivers, pulls, floating pins
`default_nettype none
module gpx_pin_model (
	// Clock
	input  wire logic       core_clk,
	// Pad controls from the port
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pullup,
	input  wire logic [7:0] pad_pulldown,
	input  wire logic [7:0] pad_analog_en,
	// Board drivers
	input  wire logic [7:0] ext_lvl,
	input  wire logic [7:0] ext_drv,
	// Resolved pin levels
	output logic      [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt = 8'h55;

	// ****************************************************************
	// Pin resolution
	// ****************************************************************
	// Undriven pins toggle so a floating read never looks like a value
	always @(posedge core_clk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drv[i] ? ext_lvl[i] :
				pad_analog_en[i] ? flt[i] : pad_pullup[i] ? 1'b1 :
				pad_pulldown[i] ? 1'b0 : flt[i];
		end
	end
endmodule // gpx_pin_model
`default_nettype wire

// file: sim/gpio_pad_irq_mux_port_tb_top.sv
// Self-checking bench for the eight-pin GPIO port
`default_nettype none
`include "gpx_consts.svh"
module gpio_pad_irq_mux_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk;
	logic        rstn;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rdata;
	logic [7:0]  pad_in;
	logic [7:0]  pad_out;
	logic [7:0]  pad_oe;
	logic [15:0] pad_drive;
	logic [7:0]  pad_slew_limit;
	logic [7:0]  pad_pullup;
	logic [7:0]  pad_pulldown;
	logic [7:0]  pad_analog_en;
	logic [15:0] func_out;
	logic [15:0] func_oe;
	logic [15:0] func_in;
	logic        irq;
	logic [7:0]  ext_lvl;
	logic [7:0]  ext_drv;
	int          err_count;
	int          n_checks;

	gpx_port u_dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_drive(pad_drive), .pad_slew_limit(pad_slew_limit),
		.pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown), .pad_analog_en(pad_analog_en),
		.func_out(func_out), .func_oe(func_oe), .func_in(func_in), .irq(irq));
	gpx_pin_model u_pins (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown), .pad_analog_en(pad_analog_en),
		.ext_lvl(ext_lvl), .ext_drv(ext_drv), .pad_in(pad_in));

	// ****************************************************************
	// Clock, bus tasks and checking
	// ****************************************************************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic complete_run;
		if (err_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		@(posedge core_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask
	function automatic logic [11:0] dat(input logic [7:0] m);
		return {2'b00, m, 2'b00};
	endfunction

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		chk("pad_oe", 32'h0000_0000, {24'h0, pad_oe});
		chk("irq", 32'h0000_0000, {31'h0, irq});
		rchk(`GPX_OFF_INT_RAW, 32'h0000_0000, "raw");
		rchk(12'h500, 32'h0000_0000, "unmapped");
		rchk(`GPX_OFF_PINCFG, 32'h0000_0000, "pincfg");
	endtask
	task automatic t_data;
		ext_lvl <= 8'hA5;
		wt(4);
		rchk(dat(8'h09), 32'h0000_0001, "masked read");
		rchk(dat(8'hFF), 32'h0000_00A5, "full read");
		wr(`GPX_OFF_DIR, 32'h0000_01F0);
		ext_drv <= 8'h0F;
		wr(dat(8'h30), 32'h0000_00FF);
		wt(4);
		chk("pad_oe", 32'h0000_00F0, {24'h0, pad_oe});
		chk("pad_out", 32'h0000_0030, {24'h0, pad_out});
		rchk(dat(8'hFF), 32'h0000_0035, "mixed read");
		wr(`GPX_OFF_DIR, 32'h0000_00F0);
		ext_drv <= 8'hFF;
	endtask
	task automatic t_pad;
		logic [31:0] w;
		logic [1:0]  d;
		wr(`GPX_OFF_PINIDX, 32'h0000_0000);
		ext_drv <= 8'hFE;
		for (int t = 0; t < 7; t++) begin
			d = 2'(t % 4);
			w = (32'(t) << 12) | (32'(d) << 8) | 32'h81;
			wr(`GPX_OFF_PAD, w);
			wt(1);
			rchk(`GPX_OFF_PINCFG, (32'(t) << 4) | 32'(d), "pad cfg");
			chk("drive", {16'h0, d, 12'h000, d}, {16'h0, pad_drive});
			chk("slew", (d == 2'h3) ? 32'h81 : 32'h0, {24'h0, pad_slew_limit});
			chk("pullup", (t == 1 || t == 4) ? 32'h81 : 32'h0, {24'h0, pad_pullup});
			chk("pulldn", (t == 2 || t == 5) ? 32'h81 : 32'h0, {24'h0, pad_pulldown});
			chk("analog", (t == 6) ? 32'h01 : 32'h0, {24'h0, pad_analog_en});
			if (t == 1 || t == 2 || t == 4 || t == 5) begin
				wt(3);
				rchk(dat(8'h01), (t == 1 || t == 4) ? 32'h1 : 32'h0, "pulled in");
			end
		end
		wr(`GPX_OFF_PAD, 32'h0000_0081);
		// Illegal codes must leave pin 0 untouched
		wr(`GPX_OFF_DIR, 32'h0000_0301);
		wr(`GPX_OFF_ITYPE, 32'h0000_5001);
		wr(`GPX_OFF_PAD, 32'h0000_7381);
		rchk(`GPX_OFF_PINCFG, 32'h0000_0000, "refused cfg");
		ext_drv <= 8'hFF;
	endtask
	task automatic t_alt;
		wr(`GPX_OFF_DIR, 32'h0000_0201);
		wr(`GPX_OFF_ALT, 32'h0005_0000);
		func_out <= 16'h0020;
		func_oe <= 16'h0020;
		ext_drv <= 8'hFE;
		wt(4);
		chk("alt oe", 32'h0000_0001, {24'h0, pad_oe});
		chk("alt out", 32'h0000_0001, {31'h0, pad_out[0]});
		chk("func_in", 32'h0000_0020, {16'h0, func_in});
		func_out <= 16'h0000;
		wt(4);
		chk("func_in lo", 32'h0000_0000, {16'h0, func_in});
		wr(`GPX_OFF_ALT, 32'h0000_0000);
		wt(2);
		chk("no func oe", 32'h0000_0000, {24'h0, pad_oe});
		wr(`GPX_OFF_DIR, 32'h0000_0001);
		ext_drv <= 8'hFF;
		func_oe <= 16'h0000;
	endtask
	task automatic t_irq;
		ext_lvl <= 8'h00;
		wt(4);
		wr(`GPX_OFF_ITYPE, 32'h0000_1003);
		wr(`GPX_OFF_INT_RAW, 32'h0000_00FF);
		wt(2);
		ext_lvl <= 8'h03;
		wt(4);
		rchk(`GPX_OFF_INT_RAW, 32'h0000_0003, "raw");
		rchk(`GPX_OFF_INT_MSK, 32'h0000_0000, "masked");
		chk("irq off", 32'h0, {31'h0, irq});
		wr(`GPX_OFF_INT_EN, 32'h0000_0001);
		rchk(`GPX_OFF_INT_EN, 32'h0000_0001, "enables");
		rchk(`GPX_OFF_INT_MSK, 32'h0000_0001, "masked");
		chk("irq on", 32'h1, {31'h0, irq});
		// Cleared at once, not as the last step of the handler
		wr(`GPX_OFF_INT_RAW, 32'h0000_0001);
		rchk(`GPX_OFF_INT_RAW, 32'h0000_0002, "raw clr");
		chk("irq clr", 32'h0, {31'h0, irq});
		wr(`GPX_OFF_INT_EN, 32'h0000_0002);
		wt(1);
		chk("irq en1", 32'h1, {31'h0, irq});
		wr(`GPX_OFF_INT_DIS, 32'h0000_0002);
		wt(1);
		chk("irq dis", 32'h0, {31'h0, irq});
		rchk(`GPX_OFF_INT_RAW, 32'h0000_0002, "raw dis");
		rchk(`GPX_OFF_INT_DIS, 32'h0000_0001, "enables");
		wr(`GPX_OFF_INT_DIS, 32'h0000_00FF);
	endtask
	task automatic t_trig;
		logic s;
		for (int k = 0; k < 5; k++) begin
			s = (k == 0 || k == 3);
			ext_lvl[4] <= s;
			wt(4);
			wr(`GPX_OFF_ITYPE, (32'(k) << 12) | 32'h10);
			wr(`GPX_OFF_INT_RAW, 32'h0000_00FF);
			wt(2);
			rchk(`GPX_OFF_INT_RAW, 32'h0000_0000, "trig idle");
			ext_lvl[4] <= ~s;
			wt(4);
			rchk(`GPX_OFF_INT_RAW, 32'h0000_0010, "trig hit");
		end
	endtask

	// ****************************************************************
	// Sequence and watchdog
	// ****************************************************************
	initial begin
		err_count = 0;
		n_checks = 0;
		rstn = 1'b0;
		addr = 12'h000;
		wdata = 32'h0000_0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		func_out = 16'h0000;
		func_oe = 16'h0000;
		ext_lvl = 8'h00;
		ext_drv = 8'hFF;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_data();
		t_pad();
		t_alt();
		t_irq();
		t_trig();
		complete_run();
	end
	// The whole sequence needs well under a thousand cycles
	initial begin
		#100us;
		err_count++;
		complete_run();
	end
endmodule // gpio_pad_irq_mux_port_tb_top
`default_nettype wire
